// [rtl/bsc_cell.sv]
// One three-bit boundary cell: capture, shift, update and the pin muxes.
// Assumes strobes are single clk_sys pulses made by the controller.
module bsc_cell
(
   input  wire logic               clk_sys,
   input  wire logic               arst_n,
   input  wire logic               capture_en,
   input  wire logic               shift_en,
   input  wire logic               update_en,
   input  wire logic               extest_en,
   input  wire logic               sdi,
   output logic                    sdo,
   input  wire bsc_pkg::bsc_core_type core,
   input  wire logic               pad_in,
   output bsc_pkg::bsc_pad_type    pad,
   output logic                    core_input_drive
);
   import bsc_pkg::*;

   // Bit 2 is the pad input, bit 1 the enable, bit 0 the value.
   logic [2:0] cap_r;
   logic [2:0] upd_r;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         cap_r <= BSC_CELL_RESET;
      else if (capture_en)
         cap_r <= {pad_in, core.enable, core.value};
      else if (shift_en)
         cap_r <= {sdi, cap_r[2:1]};
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         upd_r <= BSC_CELL_RESET;
      else if (update_en)
         upd_r <= cap_r;
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pad              <= BSC_PAD_RESET;
         core_input_drive <= 1'b0;
      end
      else if (extest_en)
      begin
         pad              <= '{oe_n: upd_r[1], out: upd_r[0]};
         core_input_drive <= upd_r[2];
      end
      else
      begin
         pad              <= '{oe_n: core.enable, out: core.value};
         core_input_drive <= pad_in;
      end
   end

   assign sdo = cap_r[0];

   AST_CAP_LOADS: assert property (@(posedge clk_sys) disable iff (!arst_n)
      capture_en |=> cap_r == {$past(pad_in), $past(core.enable), $past(core.value)})
      else $error("capture did not load cell inputs");

   AST_UPD_COPIES: assert property (@(posedge clk_sys) disable iff (!arst_n)
      update_en |=> upd_r == $past(cap_r))
      else $error("update did not copy capture bits");

   AST_SAMPLE_PASS: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !extest_en |=> pad.out == $past(core.value) && pad.oe_n == $past(core.enable))
      else $error("functional value not passed to pin");

   AST_EXTEST_DRIVE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      extest_en |=> pad.out == $past(upd_r[0]) && core_input_drive == $past(upd_r[2]))
      else $error("update data not forced in external test");

   AST_OE_TRISTATE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (extest_en && upd_r[1]) |=> pad.oe_n)
      else $error("enable update bit one did not tri-state");

endmodule

// [rtl/bsc_pkg.sv]
// Constants, types and state encoding for the boundary-scan test port.
// Assumes one system clock; all test pins are sampled into that domain.
// Functional notes
// - Sixteen-state controller, steps on TCK rise, TMS-steered.
// - Reset state: scan off, IDCODE instruction loaded.
// - Power-up places controller in reset state.
// - Five TMS-high edges or TRST low reset.
// - Stay in reset while TMS high or TRST low.
// - TDO driven only in shift states, falling edges.
// - Shift-IR presents existing instruction bits on TDO.
// - Shift-IR holds on TMS low, exits on high.
// - Instruction bits taken on rise, last on exit.
// - Sample/preload leaves normal operation undisturbed.
// - Sample/preload muxes pass functional core signals.
// - Capture loads pad input, core enable, core value.
// - Shift forms one chain from TDI to TDO.
// - Update copies capture bits into update registers.
// - TDI bit reaches TDO after whole chain.
// - Two TMS-high edges from Shift-DR reach Update-DR.
// - External test drives pins from update registers.
// - One in enable update register tri-states output.
// - Instruction register is ten bits long.
// - TRST is active-low reset, independent of TCK.
// - All-ones instruction selects one-bit bypass register.
package bsc_pkg;

   localparam int             BSC_IR_WIDTH      = 10;
   localparam int             BSC_NUM_CELLS     = 4;
   localparam logic [9:0]     BSC_IR_IDCODE     = 10'h006;
   localparam logic [9:0]     BSC_IR_SAMPLE     = 10'h005;
   localparam logic [9:0]     BSC_IR_EXTEST     = 10'h00F;
   localparam logic [9:0]     BSC_IR_BYPASS     = 10'h3FF;
   localparam logic [2:0]     BSC_TLR_TMS_COUNT = 3'h5;
   localparam logic [2:0]     BSC_CELL_RESET    = 3'h0;
   localparam logic           BSC_TDO_RESET     = 1'b0;
   localparam logic           BSC_TDO_OFF_N     = 1'b1;

   typedef enum logic [3:0] {
      ST_RESET,
      ST_IDLE,
      ST_SEL_DR,
      ST_CAP_DR,
      ST_SHIFT_DR,
      ST_EXIT1_DR,
      ST_PAUSE_DR,
      ST_EXIT2_DR,
      ST_UPD_DR,
      ST_SEL_IR,
      ST_CAP_IR,
      ST_SHIFT_IR,
      ST_EXIT1_IR,
      ST_PAUSE_IR,
      ST_EXIT2_IR,
      ST_UPD_IR
   } bsc_tap_state_type;

   // A one on enable places the buffer in high impedance, like the update register.
   typedef struct packed {
      logic enable;
      logic value;
   } bsc_core_type;

   typedef struct packed {
      logic oe_n;
      logic out;
   } bsc_pad_type;

   localparam bsc_pad_type    BSC_PAD_RESET     = '{oe_n: 1'b1, out: 1'b0};

endpackage

// [rtl/bsc_tap.sv]
// Boundary-scan test port controller with instruction register and cell chain.
// Assumes TCK, TMS, TDI, TRST and pad inputs are asynchronous to clk_sys,
// and that TCK runs well below a quarter of the clk_sys rate.
module bsc_tap
#(
   parameter int NUM_CELLS = bsc_pkg::BSC_NUM_CELLS
)
(
   input  wire logic                                   clk_sys,
   input  wire logic                                   arst_n,
   input  wire logic                                   tck,
   input  wire logic                                   tms,
   input  wire logic                                   tdi,
   input  wire logic                                   trst_n,
   output logic                                        tdo,
   output logic                                        tdo_oe_n,
   input  wire bsc_pkg::bsc_core_type [NUM_CELLS-1:0]  core_out,
   input  wire logic [NUM_CELLS-1:0]                   pad_in,
   output bsc_pkg::bsc_pad_type [NUM_CELLS-1:0]        pad_drive,
   output logic [NUM_CELLS-1:0]                        core_input_drive
);
   import bsc_pkg::*;

   localparam int SW = NUM_CELLS + 4;

   logic [SW-1:0]            sync1_r;
   logic [SW-1:0]            sync2_r;
   logic                     tck_d_r;
   logic                     tck_rise;
   logic                     tck_fall;
   logic                     tms_s;
   logic                     tdi_s;
   logic                     trst_s;
   logic [NUM_CELLS-1:0]     pad_in_s;
   bsc_tap_state_type        state_r;
   bsc_tap_state_type        state_nxt;
   logic [BSC_IR_WIDTH-1:0]  ir_shift_r;
   logic [BSC_IR_WIDTH-1:0]  ir_active_r;
   logic                     bypass_r;
   logic                     bsr_sel;
   logic                     extest_en;
   logic                     capture_en;
   logic                     shift_en;
   logic                     update_en;
   logic [NUM_CELLS:0]       chain;
   logic [2:0]               tms_ones_r;

   function automatic bsc_tap_state_type tap_next(input bsc_tap_state_type s,
                                                   input logic m);
      case (s)
         ST_RESET:    tap_next = m ? ST_RESET    : ST_IDLE;
         ST_IDLE:     tap_next = m ? ST_SEL_DR   : ST_IDLE;
         ST_SEL_DR:   tap_next = m ? ST_SEL_IR   : ST_CAP_DR;
         ST_CAP_DR:   tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_SHIFT_DR: tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR: tap_next = m ? ST_UPD_DR   : ST_PAUSE_DR;
         ST_PAUSE_DR: tap_next = m ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR: tap_next = m ? ST_UPD_DR   : ST_SHIFT_DR;
         ST_UPD_DR:   tap_next = m ? ST_SEL_DR   : ST_IDLE;
         ST_SEL_IR:   tap_next = m ? ST_RESET    : ST_CAP_IR;
         ST_CAP_IR:   tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_SHIFT_IR: tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR: tap_next = m ? ST_UPD_IR   : ST_PAUSE_IR;
         ST_PAUSE_IR: tap_next = m ? ST_EXIT2_IR : ST_PAUSE_IR;
         ST_EXIT2_IR: tap_next = m ? ST_UPD_IR   : ST_SHIFT_IR;
         ST_UPD_IR:   tap_next = m ? ST_SEL_DR   : ST_IDLE;
         default:     tap_next = ST_RESET;
      endcase
   endfunction

   function automatic logic is_bsr(input logic [BSC_IR_WIDTH-1:0] code);
      is_bsr = (code == BSC_IR_SAMPLE) || (code == BSC_IR_EXTEST);
   endfunction

   // Pins cross two flip-flops before any logic looks at them.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
         tck_d_r <= 1'b0;
      end
      else
      begin
         sync1_r <= {pad_in, trst_n, tdi, tms, tck};
         sync2_r <= sync1_r;
         tck_d_r <= sync2_r[0];
      end
   end

   assign tck_rise = sync2_r[0] & ~tck_d_r;
   assign tck_fall = ~sync2_r[0] & tck_d_r;
   assign tms_s    = sync2_r[1];
   assign tdi_s    = sync2_r[2];
   assign trst_s   = sync2_r[3];
   assign pad_in_s = sync2_r[SW-1:4];

   assign state_nxt = tap_next(state_r, tms_s);

   // Reset starts here, and a low TRST holds it regardless of TCK.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         state_r <= ST_RESET;
      else if (!trst_s)
         state_r <= ST_RESET;
      else if (tck_rise)
         state_r <= state_nxt;
   end

   // Counts TMS-high rising edges; five in a row must land in reset.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         tms_ones_r <= '0;
      else if (tck_rise)
      begin
         if (!tms_s)
            tms_ones_r <= '0;
         else if (tms_ones_r != BSC_TLR_TMS_COUNT)
            tms_ones_r <= 3'(tms_ones_r + 3'h1);
      end
   end

   // The capture loads the instruction in force, so it is what shifts out.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         ir_shift_r <= BSC_IR_IDCODE;
      else if (tck_rise && state_r == ST_CAP_IR)
         ir_shift_r <= ir_active_r;
      else if (tck_rise && state_r == ST_SHIFT_IR)
         ir_shift_r <= {tdi_s, ir_shift_r[BSC_IR_WIDTH-1:1]};
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         ir_active_r <= BSC_IR_IDCODE;
      else if (!trst_s || state_r == ST_RESET)
         ir_active_r <= BSC_IR_IDCODE;
      else if (tck_fall && state_r == ST_UPD_IR)
         ir_active_r <= ir_shift_r;
   end

   // Every code other than the two scan instructions uses the bypass bit.
   assign bsr_sel    = is_bsr(ir_active_r);
   assign extest_en  = (ir_active_r == BSC_IR_EXTEST);
   assign capture_en = tck_rise && state_r == ST_CAP_DR && bsr_sel;
   assign shift_en   = tck_rise && state_r == ST_SHIFT_DR && bsr_sel;
   assign update_en  = tck_fall && state_r == ST_UPD_DR && bsr_sel;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         bypass_r <= 1'b0;
      else if (tck_rise && state_r == ST_CAP_DR)
         bypass_r <= 1'b0;
      else if (tck_rise && state_r == ST_SHIFT_DR)
         bypass_r <= tdi_s;
   end

   assign chain[NUM_CELLS] = tdi_s;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CELLS; gi++)
      begin : g_cell
         bsc_cell u_cell
         (
            .clk_sys          (clk_sys),
            .arst_n           (arst_n),
            .capture_en       (capture_en),
            .shift_en         (shift_en),
            .update_en        (update_en),
            .extest_en        (extest_en),
            .sdi              (chain[gi+1]),
            .sdo              (chain[gi]),
            .core             (core_out[gi]),
            .pad_in           (pad_in_s[gi]),
            .pad              (pad_drive[gi]),
            .core_input_drive (core_input_drive[gi])
         );
      end
   endgenerate

   // TDO changes only on falling TCK and is released outside the shift states.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tdo      <= BSC_TDO_RESET;
         tdo_oe_n <= BSC_TDO_OFF_N;
      end
      else if (!trst_s)
         tdo_oe_n <= BSC_TDO_OFF_N;
      else if (tck_fall)
      begin
         case (state_r)
            ST_SHIFT_IR:
            begin
               tdo      <= ir_shift_r[0];
               tdo_oe_n <= 1'b0;
            end
            ST_SHIFT_DR:
            begin
               tdo      <= bsr_sel ? chain[0] : bypass_r;
               tdo_oe_n <= 1'b0;
            end
            default:
               tdo_oe_n <= BSC_TDO_OFF_N;
         endcase
      end
   end

   sequence s_shift_ir_rise;
      tck_rise && trst_s && state_r == ST_SHIFT_IR;
   endsequence

   sequence s_fall_in_shift;
      tck_fall && trst_s && (state_r == ST_SHIFT_IR || state_r == ST_SHIFT_DR);
   endsequence

   AST_FIVE_ONES_RESET: assert property (@(posedge clk_sys) disable iff (!arst_n)
      tms_ones_r == BSC_TLR_TMS_COUNT |-> state_r == ST_RESET)
      else $error("five TMS-high edges did not reach reset");

   AST_TRST_RESET: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !trst_s |=> state_r == ST_RESET && tdo_oe_n)
      else $error("TRST low did not hold reset");

   AST_STEP_ON_RISE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (!tck_rise && trst_s) |=> $stable(state_r))
      else $error("state moved without a TCK rise");

   AST_SHIFT_IR_STAY: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_shift_ir_rise |=> state_r == ($past(tms_s) ? ST_EXIT1_IR : ST_SHIFT_IR))
      else $error("Shift-IR step wrong for TMS");

   AST_IR_BIT_IN: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_shift_ir_rise |=> ir_shift_r[BSC_IR_WIDTH-1] == $past(tdi_s))
      else $error("instruction bit not taken from TDI");

   AST_TDO_DRIVE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_fall_in_shift |=> !tdo_oe_n ##1 (!tdo_oe_n || $past(tck_fall) || !$past(trst_s)))
      else $error("TDO not driven in shift state");

   AST_TDO_RELEASE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (tck_fall && state_r != ST_SHIFT_IR && state_r != ST_SHIFT_DR) |=> tdo_oe_n)
      else $error("TDO driven outside shift states");

   AST_IR_OUT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (tck_fall && trst_s && state_r == ST_SHIFT_IR) |=> tdo == $past(ir_shift_r[0]))
      else $error("instruction bit not presented on TDO");

   AST_RESET_IDCODE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      state_r == ST_RESET |=> ir_active_r == BSC_IR_IDCODE && !extest_en)
      else $error("reset state did not load IDCODE");

   AST_IR_VIA_UPDATE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $changed(ir_active_r) |-> ($past(tck_fall) && $past(state_r) == ST_UPD_IR)
                                || $past(state_r) == ST_RESET || !$past(trst_s))
      else $error("instruction changed outside Update-IR");

   sequence s_shift_dr_rise;
      tck_rise && trst_s && state_r == ST_SHIFT_DR;
   endsequence

   sequence s_update_dr_entry;
      tck_rise && trst_s && state_r == ST_EXIT1_DR && tms_s;
   endsequence

   AST_RESET_STAY: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (tck_rise && trst_s && state_r == ST_RESET && tms_s) |=> state_r == ST_RESET)
      else $error("reset state left with TMS high");

   AST_TRST_IDCODE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !trst_s |=> ir_active_r == BSC_IR_IDCODE && !extest_en)
      else $error("TRST low did not restore IDCODE");

   AST_CAPTURE_IR: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (tck_rise && trst_s && state_r == ST_CAP_IR) |=> ir_shift_r == $past(ir_active_r))
      else $error("Capture-IR did not load the active instruction");

   AST_CAPTURE_DR_STEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (tck_rise && trst_s && state_r == ST_CAP_DR) |=>
         state_r == ($past(tms_s) ? ST_EXIT1_DR : ST_SHIFT_DR))
      else $error("Capture-DR step wrong for TMS");

   AST_SHIFT_DR_EXIT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_shift_dr_rise |=> state_r == ($past(tms_s) ? ST_EXIT1_DR : ST_SHIFT_DR))
      else $error("Shift-DR step wrong for TMS");

   AST_UPDATE_DR_ENTRY: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_update_dr_entry |=> state_r == ST_UPD_DR)
      else $error("second TMS-high edge did not reach Update-DR");

   AST_BYPASS_BIT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (tck_rise && trst_s && state_r == ST_SHIFT_DR && !bsr_sel) |=> bypass_r == $past(tdi_s))
      else $error("bypass bit not taken from TDI");

   AST_BYPASS_OUT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (tck_fall && trst_s && state_r == ST_SHIFT_DR && !bsr_sel) |=> tdo == $past(bypass_r))
      else $error("bypass bit not presented on TDO");

   AST_DR_CHAIN_OUT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (tck_fall && trst_s && state_r == ST_SHIFT_DR && bsr_sel) |=> tdo == $past(chain[0]))
      else $error("chain end not presented on TDO");

endmodule

// [test/bsc_tester.sv]
// Tester model: drives the test pins of the boundary-scan port.
// Assumes clk_sys from the bench; one TCK period is eight clk_sys cycles.
module bsc_tester
(
   input  wire logic clk_sys,
   input  wire logic tdo,
   input  wire logic tdo_oe_n,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   output logic      trst_n
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      tck    = 1'b0;
      tms    = 1'b1;
      tdi    = 1'b1;
      trst_n = 1'b1;
   end

   // TCK is low for five cycles and high for three; TDO is read just before the rise.
   task automatic cyc(input logic m, input logic d, output logic q, output logic z);
      @(negedge clk_sys);
      tck = 1'b0;
      @(negedge clk_sys);
      tms = m;
      tdi = d;
      repeat (3) @(negedge clk_sys);
      q = tdo;
      z = tdo_oe_n;
      @(negedge clk_sys);
      tck = 1'b1;
      repeat (2) @(negedge clk_sys);
   endtask

   task automatic tlr(input int k);
      logic q;
      logic z;
      repeat (k) cyc(1'b1, 1'b1, q, z);
      cyc(1'b0, 1'b1, q, z);
   endtask

   // Starts and ends in Idle; from reset the preceding low step makes 0,1,1,0,0.
   task automatic ir(input logic [9:0] code, output logic [9:0] old, output logic bad);
      logic q;
      logic z;
      bad = 1'b0;
      cyc(1'b1, 1'b1, q, z);
      cyc(1'b1, 1'b1, q, z);
      cyc(1'b0, 1'b1, q, z);
      cyc(1'b0, 1'b1, q, z);
      for (int i = 0; i < 10; i++)
      begin
         cyc(i == 9, code[i], old[i], z);
         bad = bad | z;
      end
      cyc(1'b1, 1'b1, q, z);
      bad = bad | !z;
      cyc(1'b0, 1'b1, q, z);
   endtask

   task automatic dr(input logic [23:0] din, input int n, input logic pause,
                     output logic [23:0] dout);
      logic q;
      logic z;
      dout = '0;
      cyc(1'b1, 1'b1, q, z);
      cyc(1'b0, 1'b1, q, z);
      cyc(1'b0, 1'b1, q, z);
      for (int i = 0; i < n; i++)
      begin
         cyc(i == n - 1, din[i], dout[i], z);
      end
      if (pause)
      begin
         cyc(1'b0, 1'b1, q, z);
         cyc(1'b1, 1'b1, q, z);
      end
      cyc(1'b1, 1'b1, q, z);
      cyc(1'b0, 1'b1, q, z);
   endtask

   // Test reset is written only here and in the initial block, which sets it high.
   task automatic hold_trst(input logic v);
      trst_n = v;
   endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the boundary-scan port with a four-cell chain.
// Assumes the tester model drives all test pins.
`define CHK(nm, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         miscompares++; \
         $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
      end \
   end

module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import bsc_pkg::*;

   localparam int N = 4;
   logic                 clk_sys;
   logic                 arst_n;
   logic                 tck, tms, tdi, trst_n, tdo, tdo_oe_n;
   bsc_core_type [N-1:0] core_out;
   logic [N-1:0]         pad_in;
   bsc_pad_type [N-1:0]  pad_drive;
   logic [N-1:0]         core_input_drive;
   int                   miscompares;
   int                   samples_checked;

   initial clk_sys = 1'b0;
   always #25 clk_sys = ~clk_sys;

   bsc_tap #(.NUM_CELLS(N)) DUT (.clk_sys(clk_sys), .arst_n(arst_n), .tck(tck),
      .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
      .core_out(core_out), .pad_in(pad_in), .pad_drive(pad_drive),
      .core_input_drive(core_input_drive));

   bsc_tester tester (.clk_sys(clk_sys), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .tck(tck),
      .tms(tms), .tdi(tdi), .trst_n(trst_n));

   function automatic bsc_pad_type [N-1:0] thru();
      for (int i = 0; i < N; i++)
         thru[i] = '{oe_n: core_out[i].enable, out: core_out[i].value};
   endfunction

   function automatic logic [3*N-1:0] cap();
      for (int i = 0; i < N; i++)
         cap[3*i+:3] = {pad_in[i], core_out[i].enable, core_out[i].value};
   endfunction

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic pins(input bsc_pad_type [N-1:0] p, input logic [N-1:0] c);
      repeat (4) @(negedge clk_sys);
      `CHK("pad_drive", p, pad_drive);
      `CHK("core_input_drive", c, core_input_drive);
   endtask

   // Update bits per cell from the TDO end: value, enable, pad level.
   task automatic pins_upd(input logic [3*N-1:0] u);
      bsc_pad_type [N-1:0] p;
      logic [N-1:0]        c;
      for (int i = 0; i < N; i++)
      begin
         p[i] = '{oe_n: u[3*i+1], out: u[3*i]};
         c[i] = u[3*i+2];
      end
      pins(p, c);
   endtask

   task automatic load(input logic [9:0] code, input logic [9:0] exp_old);
      logic [9:0] o;
      logic       b;
      tester.ir(code, o, b);
      `CHK("ir_out", exp_old, o);
      `CHK("tdo_oe_fault", 1'b0, b);
   endtask

   task automatic sc_reset();
      `CHK("tdo_oe_n", 1'b1, tdo_oe_n);
      pins(thru(), pad_in);
      tester.tlr(0);
      load(BSC_IR_SAMPLE, BSC_IR_IDCODE);
   endtask

   task automatic sc_sample();
      logic [23:0]    o;
      logic [3*N-1:0] e;
      core_out = 8'h9C;
      pad_in = 4'h6;
      e = cap();
      tester.dr(24'h5A_3C96, 24, 1'b0, o);
      `CHK("dr_capture", e, o[11:0]);
      `CHK("dr_chain", 12'hC96, o[23:12]);
      core_out = 8'h36;
      pad_in = 4'h9;
      pins(thru(), pad_in);
   endtask

   task automatic sc_extest();
      logic [23:0]    o;
      logic [3*N-1:0] e;
      load(BSC_IR_EXTEST, BSC_IR_SAMPLE);
      pins_upd(12'h5A3);
      e = cap();
      tester.dr(24'h00_0A5C, 12, 1'b1, o);
      `CHK("dr_capture", e, o[11:0]);
      pins_upd(12'hA5C);
   endtask

   task automatic sc_bypass();
      logic [23:0] o;
      load(BSC_IR_BYPASS, BSC_IR_EXTEST);
      pins(thru(), pad_in);
      tester.dr(24'h00_0005, 3, 1'b0, o);
      `CHK("bypass_out", 3'h2, o[2:0]);
   endtask

   task automatic sc_tms_reset();
      logic q;
      logic z;
      load(BSC_IR_EXTEST, BSC_IR_BYPASS);
      tester.cyc(1'b1, 1'b1, q, z);
      tester.cyc(1'b0, 1'b1, q, z);
      tester.cyc(1'b0, 1'b1, q, z);
      tester.tlr(5);
      pins(thru(), pad_in);
      load(BSC_IR_SAMPLE, BSC_IR_IDCODE);
   endtask

   task automatic sc_trst();
      logic q;
      logic z;
      int   k;
      load(BSC_IR_EXTEST, BSC_IR_SAMPLE);
      tester.cyc(1'b1, 1'b1, q, z);
      tester.cyc(1'b1, 1'b1, q, z);
      tester.cyc(1'b0, 1'b1, q, z);
      tester.cyc(1'b0, 1'b1, q, z);
      tester.cyc(1'b0, 1'b1, q, z);
      `CHK("tdo_oe_n", 1'b0, z);
      tester.hold_trst(1'b0);
      for (k = 0; k < 8 && tdo_oe_n !== 1'b1; k++)
         @(negedge clk_sys);
      `CHK("tdo_oe_n", 1'b1, tdo_oe_n);
      if (k == 8)
         stop_test();
      pins(thru(), pad_in);
      tester.hold_trst(1'b1);
      tester.tlr(0);
      load(BSC_IR_SAMPLE, BSC_IR_IDCODE);
   endtask

   initial
   begin
      arst_n = 1'b0;
      core_out = 8'h5A;
      pad_in = 4'h3;
      miscompares = 0;
      samples_checked = 0;
      repeat (8) @(negedge clk_sys);
      arst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      sc_reset();
      sc_sample();
      sc_extest();
      sc_bypass();
      sc_tms_reset();
      sc_trst();
      stop_test();
   end
endmodule
